//--- pafm_pkg.sv
// Constants for the port alternate-function multiplexer.
// Assumes five 8-bit ports, flattened as bit 8*port+pin.
package pafm_pkg;
    localparam int PAFM_PORTS = 5;
    localparam int PAFM_PINS = 40;
    // Mode pair written {pin_mode_bit_high, pin_mode_bit_low}
    localparam logic [1:0] PAFM_MODE_QUASI = 2'h0;
    localparam logic [1:0] PAFM_MODE_INPUT = 2'h1;
    localparam logic [1:0] PAFM_MODE_PUSH = 2'h2;
    localparam logic [1:0] PAFM_MODE_DRAIN = 2'h3;
    // Values after reset
    localparam logic [7:0] PAFM_LATCH_RESET = 8'hff;
    localparam logic [7:0] PAFM_HIGH_RESET = 8'h00;
    localparam logic [7:0] PAFM_ALL_INPUT_LOW = 8'hff;
    // Analog-capable pins: converter channels on port 0, comparator and converter pins on port 2
    localparam logic [39:0] PAFM_ANALOG_MASK = 40'h0000fc00ff;
    // Pin positions with special handling
    localparam int PAFM_DAC_POS_PIN = 18;
    localparam int PAFM_DAC_NEG_PIN = 19;
    localparam int PAFM_SHARED_MODE_SRC = 29;
    localparam int PAFM_RESET_PIN = 34;
    localparam int PAFM_CMP_ONE_PIN = 38;
    localparam int PAFM_CMP_TWO_PIN = 39;
endpackage : pafm_pkg

//--- pafm_pin_if.sv
// Bundle between the configuration logic and the pin driver stage.
// Assumes one clock domain; all vectors are one bit per pin.
interface pafm_pin_if;
    logic [39:0] mode_low;
    logic [39:0] mode_high;
    logic [39:0] latch;
    logic [39:0] alt_drive;
    logic [39:0] pin_level;
    logic [39:0] pin_out;
    logic [39:0] pin_oe;
    logic [39:0] pull_up;
    logic [39:0] alt_in;
    modport ctrl (output mode_low, output mode_high, output latch, output alt_drive, output pin_level,
                  input pin_out, input pin_oe, input pull_up, input alt_in);
    modport drive (input mode_low, input mode_high, input latch, input alt_drive, input pin_level,
                   output pin_out, output pin_oe, output pull_up, output alt_in);
endinterface : pafm_pin_if

//--- pafm_pin_drive.sv
// Per-pin output driver and alternate input gating, all pins as vectors.
// Assumes pin levels arrive already synchronised and effective modes resolved.
module pafm_pin_drive
    import pafm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    pafm_pin_if.drive pins
);
    logic [39:0] drive_val;
    logic [39:0] input_only;
    logic [39:0] push_pull;
    logic [39:0] quasi;
    logic [39:0] next_oe;
    logic [39:0] next_alt_in;

    // Mode decode and AND-combined data paths
    assign drive_val = pins.latch & pins.alt_drive;
    assign input_only = pins.mode_low & ~pins.mode_high;
    assign push_pull = ~pins.mode_low & pins.mode_high;
    assign quasi = ~pins.mode_low & ~pins.mode_high;
    assign next_oe = ~input_only & (push_pull | ~drive_val);
    assign next_alt_in = pins.pin_level & (pins.latch | input_only);

    // Registered pin and peripheral outputs
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pins.pin_out <= '0;
            pins.pin_oe <= '0;
            pins.pull_up <= '0;
            pins.alt_in <= '0;
        end else begin
            pins.pin_out <= drive_val;
            pins.pin_oe <= next_oe;
            pins.pull_up <= quasi & pins.latch; // Weak pull-up only in quasi mode
            pins.alt_in <= next_alt_in;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    chk_latch_low_out: assert property ((pins.pin_out & ~$past(pins.latch)) == '0)
        else $error("pin driven high while latch cleared");
    chk_latch_low_in: assert property ((pins.alt_in & ~$past(pins.latch) & ~$past(input_only)) == '0)
        else $error("alternate input passed with latch cleared outside input mode");
    // Outputs still hold their reset zeros at the first edge after release
    chk_input_bypass: assert property (!$past(srst_i) |->
                                       (((~pins.alt_in) & $past(input_only) & $past(pins.pin_level)) == '0))
        else $error("input-only pin lost its alternate input");
    chk_input_tristate: assert property ((pins.pin_oe & $past(input_only)) == '0)
        else $error("input-only pin is driven");
    chk_push_drive: assert property (!$past(srst_i) |-> (((~pins.pin_oe) & $past(push_pull)) == '0))
        else $error("push-pull pin not driven");
    chk_and_input: assert property ((pins.alt_in & ~$past(pins.pin_level)) == '0)
        else $error("alternate input high while pin low");
endmodule : pafm_pin_drive

//--- pafm_mux.sv
// Port alternate-function multiplexer top: latch and mode storage, mode overrides, pin sync.
// Assumes software writes latch and mode bits one port at a time through the write strobes,
// and peripherals drive alt_out_i high on pins they do not use.
module pafm_mux
    import pafm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic tristate_fuse_i,
    input wire logic [2:0] port_sel_i,
    input wire logic latch_wr_i,
    input wire logic [7:0] latch_data_i,
    input wire logic mode_wr_i,
    input wire logic [7:0] mode_low_data_i,
    input wire logic [7:0] mode_high_data_i,
    input wire logic reset_disable_i,
    input wire logic dac_mode_i,
    input wire logic comparator_one_output_i,
    input wire logic comparator_two_output_i,
    input wire logic [39:0] alt_out_i,
    output logic [39:0] alt_in_o,
    input wire logic [39:0] pin_in_i,
    output logic [39:0] pin_out_o,
    output logic [39:0] pin_oe_o,
    output logic [39:0] pin_pull_up_o,
    output logic [39:0] latch_o,
    output logic [39:0] pin_level_o
);
    pafm_pin_if pins ();

    logic [39:0] pin_meta;
    logic [39:0] pin_sync;
    logic fuse_meta;
    logic fuse_sync;
    logic [39:0] latch_q;
    logic [39:0] mode_low_q;
    logic [39:0] mode_high_q;
    logic [39:0] shared_low;
    logic [39:0] shared_high;
    logic [39:0] force_input;
    logic [39:0] cmp_mask;
    logic [39:0] alt_src;

    // True when the write select names this port
    function automatic logic port_hit(input logic [2:0] sel, input int unsigned p);
        port_hit = (sel == p[2:0]);
    endfunction : port_hit

    // Two-stage synchronisers for pins and the mode fuse
    always_ff @(posedge clk_sys_i) begin
        pin_meta <= pin_in_i;
        pin_sync <= pin_meta;
        fuse_meta <= tristate_fuse_i;
        fuse_sync <= fuse_meta;
    end

    // Per-port latch and mode storage
    for (genvar p = 0; p < PAFM_PORTS; p++) begin : g_port
        always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
                latch_q[8*p +: 8] <= PAFM_LATCH_RESET;
                mode_low_q[8*p +: 8] <= fuse_sync ? PAFM_ALL_INPUT_LOW : PAFM_ANALOG_MASK[8*p +: 8];
                mode_high_q[8*p +: 8] <= PAFM_HIGH_RESET;
            end else begin
                if (latch_wr_i && port_hit(port_sel_i, p)) begin
                    latch_q[8*p +: 8] <= latch_data_i;
                end
                if (mode_wr_i && port_hit(port_sel_i, p)) begin
                    mode_low_q[8*p +: 8] <= mode_low_data_i;
                    mode_high_q[8*p +: 8] <= mode_high_data_i;
                end
            end
        end
    end

    // Reset pin borrows another pin's mode bits
    assign shared_low = {mode_low_q[39:PAFM_RESET_PIN+1], mode_low_q[PAFM_SHARED_MODE_SRC],
                         mode_low_q[PAFM_RESET_PIN-1:0]};
    assign shared_high = {mode_high_q[39:PAFM_RESET_PIN+1], mode_high_q[PAFM_SHARED_MODE_SRC],
                          mode_high_q[PAFM_RESET_PIN-1:0]};

    // Forced input-only pins and fixed comparator pins
    assign force_input = ({39'h0, dac_mode_i} << PAFM_DAC_POS_PIN)
                       | ({39'h0, dac_mode_i} << PAFM_DAC_NEG_PIN)
                       | ({39'h0, ~reset_disable_i} << PAFM_RESET_PIN);
    assign cmp_mask = (40'h1 << PAFM_CMP_ONE_PIN) | (40'h1 << PAFM_CMP_TWO_PIN);

    // Effective modes handed to the driver stage
    assign pins.mode_low = (shared_low | force_input) & ~cmp_mask;
    assign pins.mode_high = (shared_high & ~force_input) | cmp_mask;
    assign pins.latch = latch_q | cmp_mask;
    assign alt_src = {comparator_two_output_i, comparator_one_output_i, alt_out_i[37:0]};
    assign pins.alt_drive = alt_src;
    assign pins.pin_level = pin_sync;

    pafm_pin_drive u_drive (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .pins(pins)
    );

    // Outputs to pins, peripherals and software readback
    assign pin_out_o = pins.pin_out;
    assign pin_oe_o = pins.pin_oe;
    assign pin_pull_up_o = pins.pull_up;
    assign alt_in_o = pins.alt_in;
    assign latch_o = latch_q;
    assign pin_level_o = pin_sync;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    // Comparator pins checked once the driver stage has left its reset zeros
    chk_cmp_one_pin: assert property (!$past(srst_i) |-> pin_oe_o[PAFM_CMP_ONE_PIN]
                                      && pin_out_o[PAFM_CMP_ONE_PIN] == $past(comparator_one_output_i))
        else $error("comparator one pin not following comparator");
    chk_cmp_two_pin: assert property (!$past(srst_i) |-> pin_oe_o[PAFM_CMP_TWO_PIN]
                                      && pin_out_o[PAFM_CMP_TWO_PIN] == $past(comparator_two_output_i))
        else $error("comparator two pin not following comparator");
    chk_dac_force_in: assert property (dac_mode_i |=> !pin_oe_o[PAFM_DAC_POS_PIN] && !pin_oe_o[PAFM_DAC_NEG_PIN])
        else $error("converter output pins driven in converter output mode");
    chk_reset_pin_hold: assert property (!reset_disable_i |=> !pin_oe_o[PAFM_RESET_PIN])
        else $error("reset pin driven while reset function enabled");
    chk_analog_reset: assert property ($past(srst_i) |-> ((mode_low_q & ~mode_high_q & PAFM_ANALOG_MASK)
                                                         == PAFM_ANALOG_MASK))
        else $error("analog pin not input-only after reset");
    // Writes to a select beyond the last port leave the latches alone
    chk_refused_sel: assert property (port_sel_i > 3'h4 |=> latch_q == $past(latch_q))
        else $error("latch changed by write to absent port");
    chk_latch_port0: assert property (latch_wr_i && port_sel_i == 3'h0 |=> latch_o[7:0] == $past(latch_data_i))
        else $error("port zero latch write not taken");
    // Pin levels reach the readback after the two synchroniser stages
    chk_pin_sync: assert property (!$past(srst_i) |-> pin_level_o == $past(pin_in_i, 2))
        else $error("pin level readback not two stages behind pin");
    chk_cmp_pull_off: assert property (!$past(srst_i) |-> pin_pull_up_o[PAFM_CMP_TWO_PIN:PAFM_CMP_ONE_PIN] == 2'h0)
        else $error("weak pull-up on comparator pin");
endmodule : pafm_mux

//--- pafm_pad_model.sv
// Pad model: resolves each pad from the block's drive, its pull-up and an outside level.
// Assumes the bench supplies the level outside parts put on released pads.
module pafm_pad_model (
    input wire logic [39:0] pin_out_i,
    input wire logic [39:0] pin_oe_i,
    input wire logic [39:0] pin_pull_up_i,
    input wire logic [39:0] ext_level_i,
    output logic [39:0] pin_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Driven pads follow the block, released pads the pull-up or the outside part
    assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & (pin_pull_up_i | ext_level_i));
endmodule : pafm_pad_model

//--- tb_port_alternate_function_mux.sv
// Self-checking bench for the alternate-function multiplexer.
// Assumes the pad model closes the loop from pin drive back to pin_in_i.
module tb_port_alternate_function_mux;
    import pafm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int unsigned sel; logic [39:0] mask; logic [39:0] exp;} pafm_note_t;
    logic clk_sys_i, srst_i, latch_wr_i, mode_wr_i, reset_disable_i, dac_mode_i, cmp_one, cmp_two;
    logic [2:0] port_sel_i;
    logic [7:0] latch_data_i, mode_low_data_i, mode_high_data_i, lat, lo, hi, a, x, o, oe, pu, w, inb, push;
    logic [39:0] alt_out_i, alt_in_o, pin_in_i, pin_out_o, pin_oe_o, pin_pull_up_o, latch_o, ext, act, lvl;
    pafm_note_t notes[$];
    pafm_note_t n;
    int num_errors = 0;
    int checked = 0;
    int p;
    event obs_ev;
    pafm_mux DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .tristate_fuse_i(1'b0), .port_sel_i(port_sel_i),
        .latch_wr_i(latch_wr_i), .latch_data_i(latch_data_i), .mode_wr_i(mode_wr_i),
        .mode_low_data_i(mode_low_data_i), .mode_high_data_i(mode_high_data_i),
        .reset_disable_i(reset_disable_i), .dac_mode_i(dac_mode_i), .comparator_one_output_i(cmp_one),
        .comparator_two_output_i(cmp_two), .alt_out_i(alt_out_i), .alt_in_o(alt_in_o), .pin_in_i(pin_in_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pull_up_o(pin_pull_up_o), .latch_o(latch_o),
        .pin_level_o(lvl));
    pafm_pad_model pads (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pin_pull_up_i(pin_pull_up_o),
        .ext_level_i(ext), .pin_level_o(pin_in_i));
    // Clock at 125 MHz
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // Monitor: on each event, drains every queued note and compares each with the output it selects
    always @(obs_ev) begin
        while (notes.size() > 0) begin
            n = notes.pop_front();
            act = n.sel == 0 ? pin_out_o : n.sel == 1 ? pin_oe_o : n.sel == 2 ? pin_pull_up_o :
                  n.sel == 3 ? alt_in_o : n.sel == 4 ? latch_o : lvl;
            checked++;
            if ((act & n.mask) !== (n.exp & n.mask)) begin
                num_errors++;
                $display("mismatch t=%0t got %h exp %h", $time, act & n.mask, n.exp & n.mask);
            end
        end
    end
    task automatic note(input int unsigned s, input logic [39:0] m, input logic [39:0] e);
        notes.push_back('{s, m, e});
    endtask : note
    // One write at the falling edge, then wait out the pin and sync latency
    task automatic wr(input logic lw, input logic mw, input logic [2:0] s, input logic [7:0] d,
                      input logic [15:0] m);
        @(negedge clk_sys_i);
        {latch_wr_i, mode_wr_i, port_sel_i, latch_data_i, mode_high_data_i, mode_low_data_i} = {lw, mw, s, d, m};
        @(negedge clk_sys_i);
        {latch_wr_i, mode_wr_i} = 2'h0;
        repeat (6) @(negedge clk_sys_i);
    endtask : wr
    task finish_test;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    // Hang guard
    initial begin
        #600000;
        num_errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hc10b5531));
        {srst_i, latch_wr_i, mode_wr_i, port_sel_i, latch_data_i} = {1'b1, 13'h0};
        {mode_low_data_i, mode_high_data_i, reset_disable_i, dac_mode_i, cmp_one, cmp_two} = 20'h0;
        alt_out_i = '1;
        ext = 40'h0;
        repeat (8) @(negedge clk_sys_i);
        srst_i = 1'b0;
        wr(1'b1, 1'b0, 3'h5, 8'h00, 16'h0000);
        note(4, '1, '1);
        note(1, PAFM_ANALOG_MASK, 40'h0);
        note(2, '1, ~PAFM_ANALOG_MASK & 40'h3bffffffff);
        -> obs_ev;
        wr(1'b0, 1'b1, 3'h0, 8'h00, 16'h00ff);
        note(1, 40'hff, 40'h0);
        -> obs_ev;
        $display("test reset and refused write done");
        // Random modes, latches and peripheral levels on ports 0..3, mode set before use
        for (int i = 0; i < 60; i++) begin
            p = $urandom % 4;
            {lat, lo, hi, a, x} = {$urandom, $urandom} & 40'hff_ffff_ffff;
            alt_out_i[8*p+:8] = a;
            ext[8*p+:8] = x;
            wr(1'b1, 1'b1, p[2:0], lat, {hi, lo});
            inb = lo & ~hi;
            push = hi & ~lo;
            o = lat & a;
            oe = push | (~inb & ~push & ~o);
            pu = ~lo & ~hi & lat;
            w = (oe & o) | (~oe & (pu | x));
            note(0, 40'hff << 8*p, {32'h0, o} << 8*p);
            note(1, 40'hff << 8*p, {32'h0, oe} << 8*p);
            note(2, 40'hff << 8*p, {32'h0, pu} << 8*p);
            note(3, 40'hff << 8*p, {32'h0, w & (lat | inb)} << 8*p);
            note(5, 40'hff << 8*p, {32'h0, w} << 8*p);
            -> obs_ev;
        end
        $display("test random modes done");
        dac_mode_i = 1'b1;
        wr(1'b1, 1'b1, 3'h2, 8'hff, 16'hff00);
        note(1, 40'hff0000, 40'hf30000);
        -> obs_ev;
        dac_mode_i = 1'b0;
        wr(1'b0, 1'b0, 3'h0, 8'h00, 16'h0000);
        note(1, 40'hff0000, 40'hff0000);
        -> obs_ev;
        $display("test converter override done");
        alt_out_i[34] = 1'b1;
        wr(1'b1, 1'b1, 3'h3, 8'hff, 16'h2000);
        wr(1'b1, 1'b1, 3'h4, 8'hff, 16'h0000);
        note(1, 40'h0400000000, 40'h0);
        -> obs_ev;
        reset_disable_i = 1'b1;
        wr(1'b0, 1'b0, 3'h0, 8'h00, 16'h0000);
        note(1, 40'h0400000000, 40'h0400000000);
        note(0, 40'h0400000000, 40'h0400000000);
        -> obs_ev;
        wr(1'b1, 1'b0, 3'h4, 8'hfb, 16'h0000);
        note(0, 40'h0400000000, 40'h0);
        -> obs_ev;
        $display("test shared reset pin done");
        for (int i = 0; i < 4; i++) begin
            {cmp_one, cmp_two} = i[1:0];
            wr(1'b1, 1'b1, 3'h4, 8'h00, 16'hc0c0);
            note(0, 40'hc000000000, {cmp_two, cmp_one, 38'h0});
            note(1, 40'hc000000000, 40'hc000000000);
            -> obs_ev;
        end
        $display("test comparator pins done");
        @(negedge clk_sys_i);
        finish_test();
    end
endmodule : tb_port_alternate_function_mux
